// [verilog/ioge_pkg.sv]
// Purpose: constants for the increment / or / branch execution block
// Assumes: 14-bit instruction words, 8-bit data, 13-bit program counter
// Notes:   opcode encodings are local constants of this block
// Function
// [RULE1] destination bit picks accumulator or file register
// [RULE2] increment-skip: no flags, zero result inserts no-op
// [RULE3] increment stores sum and updates zero flag
// [RULE4] branch loads immediate plus page latch bits
// [RULE5] branch takes two cycles, no flags changed
// [RULE6] or-literal into accumulator, zero flag updated
// [RULE7] or-register to destination, zero flag updated
// [RULE8] eight-bit wrap; zero flag set exactly when zero
package ioge_pkg;
    // ************************************************************
    // widths
    // ************************************************************
    localparam int IOGE_IW   = 14;
    localparam int IOGE_DW   = 8;
    localparam int IOGE_AW   = 7;
    localparam int IOGE_PCW  = 13;
    localparam int IOGE_BRW  = 11;
    localparam int IOGE_DEPTH = 128;
    // ************************************************************
    // instruction fields
    // ************************************************************
    localparam int OPC_HI    = 13;
    localparam int OPC_LO    = 8;
    localparam int BRC_LO    = 11;
    localparam int DEST_BIT  = 7;
    localparam int PAGE_HI   = 4;
    localparam int PAGE_LO   = 3;
    localparam logic [5:0] OPC_INC_REG  = 6'h0a;
    localparam logic [5:0] OPC_INC_SKIP = 6'h0f;
    localparam logic [5:0] OPC_OR_REG   = 6'h04;
    localparam logic [5:0] OPC_OR_LIT   = 6'h38;
    localparam logic [2:0] OPC_BRANCH = 3'h5;
    // ************************************************************
    // reset values and steps
    // ************************************************************
    localparam logic [IOGE_DW-1:0]  ACC_RST  = 8'h00;
    localparam logic [IOGE_DW-1:0]  DATA_ONE = 8'h01;
    localparam logic [IOGE_DW-1:0]  DATA_ZERO = 8'h00;
    localparam logic [IOGE_PCW-1:0] PC_RST   = 13'h0000;
    localparam logic [IOGE_PCW-1:0] PC_STEP  = 13'h0001;

    typedef enum logic [1:0] {IOGE_IDLE, IOGE_EXEC, IOGE_FLUSH} ioge_state_type;
endpackage

// [verilog/ioge_file_ram.sv]
// Purpose: file register space, one write port, registered read
// Assumes: single clock, read data valid one cycle after address
// Notes:   array has no reset; contents are loaded through the write port
`timescale 1ns/10ps
module ioge_file_ram
    import ioge_pkg::*;
(
    // clock
    input  wire logic                         clk_sys,
    // write port
    input  wire logic                         wr_en,
    input  wire logic [ioge_pkg::IOGE_AW-1:0] wr_addr,
    input  wire logic [ioge_pkg::IOGE_DW-1:0] wr_data,
    // read port
    input  wire logic [ioge_pkg::IOGE_AW-1:0] rd_addr,
    output logic      [ioge_pkg::IOGE_DW-1:0] rd_data_r
);
    import ioge_pkg::*;

    logic [IOGE_DW-1:0] mem [IOGE_DEPTH];

    // write and registered read
    always_ff @(posedge clk_sys)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_r <= mem[rd_addr];
    end
endmodule

// [verilog/ioge_exec.sv]
// Purpose: executes increment, increment-skip, or-literal, or-register, branch
// Assumes: instruction offered with a valid/ready handshake on clk_sys
// Notes:   file register space sits in ioge_file_ram with a preload port
`timescale 1ns/10ps
module ioge_exec
    import ioge_pkg::*;
(
    // clock and reset
    input  wire logic                         clk_sys,
    input  wire logic                         rst,
    // instruction in
    input  wire logic                         instr_valid,
    input  wire logic [ioge_pkg::IOGE_IW-1:0] instr_word,
    output logic                              instr_ready,
    // page latch contents
    input  wire logic [ioge_pkg::IOGE_DW-1:0] program_page_latch,
    // file register preload
    input  wire logic                         preload_en,
    input  wire logic [ioge_pkg::IOGE_AW-1:0] preload_addr,
    input  wire logic [ioge_pkg::IOGE_DW-1:0] preload_data,
    // core state out
    output logic      [ioge_pkg::IOGE_DW-1:0] accum_r,
    output logic                              zero_flag_r,
    output logic      [ioge_pkg::IOGE_PCW-1:0] pc_r,
    output logic                              instr_done_r,
    output logic                              no_operation_r
);
    import ioge_pkg::*;

    ioge_state_type      state_r, state_nxt;
    logic [IOGE_IW-1:0]  op_r;
    logic                skip_r, skip_nxt;
    logic [IOGE_DW-1:0]  accum_nxt;
    logic                zero_nxt;
    logic [IOGE_PCW-1:0] pc_nxt;
    logic                done_nxt;
    logic [IOGE_DW-1:0]  rd_data_r;

    // ************************************************************
    // decode of the offered word
    // ************************************************************
    wire        in_is_branch = instr_word[OPC_HI:BRC_LO] == OPC_BRANCH;
    wire        in_is_orlit  = instr_word[OPC_HI:OPC_LO] == OPC_OR_LIT;
    wire        in_is_file   = (instr_word[OPC_HI:OPC_LO] == OPC_INC_REG)
                             | (instr_word[OPC_HI:OPC_LO] == OPC_INC_SKIP)
                             | (instr_word[OPC_HI:OPC_LO] == OPC_OR_REG);
    wire        take         = instr_valid & instr_ready;
    wire [IOGE_DW-1:0] or_lit_res = accum_r | instr_word[IOGE_DW-1:0];   // see [RULE6]
    wire [IOGE_PCW-1:0] branch_pc = {program_page_latch[PAGE_HI:PAGE_LO],
                                     instr_word[IOGE_BRW-1:0]};           // see [RULE4]
    wire [IOGE_PCW-1:0] pc_inc    = pc_r + PC_STEP;

    // ************************************************************
    // decode and result of the held file-register instruction
    // ************************************************************
    wire        op_inc    = op_r[OPC_HI:OPC_LO] == OPC_INC_REG;
    wire        op_skip   = op_r[OPC_HI:OPC_LO] == OPC_INC_SKIP;
    wire        op_dest   = op_r[DEST_BIT];
    wire [IOGE_DW-1:0] inc_res  = rd_data_r + DATA_ONE;                   // see [RULE8]
    wire [IOGE_DW-1:0] file_res = (op_inc | op_skip) ? inc_res
                                                        : (accum_r | rd_data_r); // see [RULE7]
    wire        file_zero = file_res == DATA_ZERO;                        // see [RULE8]
    wire        in_exec   = state_r == IOGE_EXEC;
    wire        file_wr   = in_exec & op_dest;                            // see [RULE1]

    // ram ports: preload owns the write port while idle
    wire                ram_we    = file_wr | (preload_en & (state_r == IOGE_IDLE));
    wire [IOGE_AW-1:0]  ram_waddr = file_wr ? op_r[IOGE_AW-1:0] : preload_addr;
    wire [IOGE_DW-1:0]  ram_wdata = file_wr ? file_res : preload_data;

    assign instr_ready = (state_r == IOGE_IDLE) & ~preload_en;

    ioge_file_ram u_ram
    (
        .clk_sys   (clk_sys),
        .wr_en     (ram_we),
        .wr_addr   (ram_waddr),
        .wr_data   (ram_wdata),
        .rd_addr   (instr_word[IOGE_AW-1:0]),
        .rd_data_r (rd_data_r)
    );

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb
    begin
        state_nxt = state_r;
        skip_nxt  = skip_r;
        accum_nxt = accum_r;
        zero_nxt  = zero_flag_r;
        pc_nxt    = pc_r;
        done_nxt  = 1'b0;
        case (state_r)
            IOGE_IDLE:
            begin
                if (take)
                begin
                    if (in_is_branch)
                    begin
                        pc_nxt    = branch_pc;                 // see [RULE4]
                        skip_nxt  = 1'b0;
                        state_nxt = IOGE_FLUSH;                // see [RULE5]
                    end
                    else if (in_is_file)
                    begin
                        state_nxt = IOGE_EXEC;
                    end
                    else
                    begin
                        if (in_is_orlit)
                        begin
                            accum_nxt = or_lit_res;            // see [RULE6]
                            zero_nxt  = or_lit_res == DATA_ZERO;
                        end
                        pc_nxt   = pc_inc;
                        done_nxt = 1'b1;
                    end
                end
            end
            IOGE_EXEC:
            begin
                if (!op_dest)
                begin
                    accum_nxt = file_res;                      // see [RULE1]
                end
                if (!op_skip)
                begin
                    zero_nxt = file_zero;                      // see [RULE3]
                end
                pc_nxt = pc_inc;
                if (op_skip && file_zero)
                begin
                    skip_nxt  = 1'b1;                          // see [RULE2]
                    state_nxt = IOGE_FLUSH;
                end
                else
                begin
                    done_nxt  = 1'b1;
                    state_nxt = IOGE_IDLE;
                end
            end
            IOGE_FLUSH:
            begin
                if (skip_r)
                begin
                    pc_nxt = pc_inc;                           // see [RULE2]
                end
                done_nxt  = 1'b1;
                state_nxt = IOGE_IDLE;
            end
            default:
            begin
                state_nxt = IOGE_IDLE;
            end
        endcase
    end

    // ************************************************************
    // state registers
    // ************************************************************
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_r        <= IOGE_IDLE;
            skip_r         <= 1'b0;
            accum_r        <= ACC_RST;
            zero_flag_r    <= 1'b0;
            pc_r           <= PC_RST;
            instr_done_r   <= 1'b0;
            no_operation_r <= 1'b0;
        end
        else
        begin
            state_r        <= state_nxt;
            skip_r         <= skip_nxt;
            accum_r        <= accum_nxt;
            zero_flag_r    <= zero_nxt;
            pc_r           <= pc_nxt;
            instr_done_r   <= done_nxt;
            no_operation_r <= state_nxt == IOGE_FLUSH;
        end
    end

    // held instruction word for the read cycle
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            op_r <= '0;
        end
        else if (take)
        begin
            op_r <= instr_word;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    wire [IOGE_DW-1:0] acc_q   = accum_r;
    wire               branch_take = take & in_is_branch;

    dest_acc_a: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE1]
        in_exec & ~op_dest |=> accum_r == $past(file_res))
        else $error("accumulator not loaded for destination zero");
    dest_keep_a: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE1]
        in_exec & op_dest |=> accum_r == $past(acc_q))
        else $error("accumulator changed for destination one");
    skip_flag_a: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE2]
        in_exec & op_skip |=> $stable(zero_flag_r))
        else $error("increment-skip changed the zero flag");
    skip_nop_a: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE2]
        in_exec & op_skip & (rd_data_r == 8'hff) |=> no_operation_r ##1 instr_done_r)
        else $error("zero result did not insert a no-op cycle");
    inc_zero_a: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE3]
        in_exec & op_inc |=> zero_flag_r == ($past(rd_data_r) == 8'hff))
        else $error("increment zero flag wrong");
    branch_pc_a: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE4]
        branch_take |=> pc_r == {$past(program_page_latch[PAGE_HI:PAGE_LO]),
                                 $past(instr_word[IOGE_BRW-1:0])})
        else $error("branch target wrong");
    branch_two_a: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE5]
        branch_take |=> !instr_ready && $stable(zero_flag_r) ##1 instr_done_r && instr_ready)
        else $error("branch not two cycles or flag changed");
    or_lit_a: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE6]
        take & in_is_orlit |=> accum_r == ($past(acc_q) | $past(instr_word[IOGE_DW-1:0]))
                               && zero_flag_r == (accum_r == 8'h00))
        else $error("or-literal result or flag wrong");
    or_reg_a: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE7]
        in_exec & ~op_inc & ~op_skip |=> zero_flag_r == ($past(file_res) == 8'h00))
        else $error("or-register zero flag wrong");
    inc_wrap_a: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE8]
        in_exec & op_inc & ~op_dest & (rd_data_r == 8'hff) |=> accum_r == 8'h00 && zero_flag_r)
        else $error("increment did not wrap to zero");

    skip_c:   cover property (@(posedge clk_sys) disable iff (rst)
        in_exec & op_skip & file_zero);
    branch_c: cover property (@(posedge clk_sys) disable iff (rst) branch_take);
    orreg_c:  cover property (@(posedge clk_sys) disable iff (rst)
        in_exec & ~op_inc & ~op_skip & op_dest);
endmodule

// [test/ioge_fetch_model.sv]
// Purpose: fetch unit model that offers one instruction word at a time
// Assumes: words change at the falling edge and are held until taken
// Notes:   a released word bus shows the inverse of the last word
`timescale 1ns/10ps
module ioge_fetch_model
    import ioge_pkg::*;
(
    // clock and handshake
    input  wire logic                         clk_sys,
    input  wire logic                         instr_ready,
    output logic                              instr_valid,
    output logic      [ioge_pkg::IOGE_IW-1:0] instr_word
);
    bit taken;

    // idle bus at time zero
    initial
    begin
        instr_valid = 1'b0;
        instr_word  = '0;
        taken       = 1'b0;
    end

    // release after the taking edge, so stale words never linger
    always @(negedge clk_sys)
    begin
        if (taken)
        begin
            instr_valid = 1'b0;
            instr_word  = ~instr_word;
            taken       = 1'b0;
        end
    end

    // offer a word; returns at the edge that takes it
    task automatic send(input logic [IOGE_IW-1:0] w, output bit ok);
        int i;
        ok = 1'b0;
        @(negedge clk_sys);
        instr_valid = 1'b1;
        instr_word  = w;
        for (i = 0; i < 20 && !ok; i++)
        begin
            if (instr_ready === 1'b1)
                ok = 1'b1;
            else
                @(negedge clk_sys);
        end
        @(posedge clk_sys);
        taken = 1'b1;
    endtask
endmodule

// [test/tb_top.sv]
// Purpose: self-checking bench for the execution block
// Assumes: a reference model of accumulator, flag, counter and file space
// Notes:   inputs change at the falling edge, outputs sampled there too
`timescale 1ns/10ps
module tb_top
    import ioge_pkg::*;
    ;
    logic                clk_sys;
    logic                rst;
    logic                instr_valid;
    logic [IOGE_IW-1:0]  instr_word;
    logic                instr_ready;
    logic [IOGE_DW-1:0]  program_page_latch;
    logic                preload_en;
    logic [IOGE_AW-1:0]  preload_addr;
    logic [IOGE_DW-1:0]  preload_data;
    logic [IOGE_DW-1:0]  accum_r;
    logic                zero_flag_r;
    logic [IOGE_PCW-1:0] pc_r;
    logic                instr_done_r;
    logic                no_operation_r;
    logic [IOGE_DW-1:0]  acc_m;
    logic [IOGE_DW-1:0]  ram_m [IOGE_DEPTH];
    logic                z_m;
    logic [IOGE_PCW-1:0] pc_m;
    int                  mismatches;
    int                  num_checks;

    ioge_exec dut_u (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_ready(instr_ready),
        .program_page_latch(program_page_latch), .preload_en(preload_en),
        .preload_addr(preload_addr), .preload_data(preload_data), .accum_r(accum_r),
        .zero_flag_r(zero_flag_r), .pc_r(pc_r), .instr_done_r(instr_done_r),
        .no_operation_r(no_operation_r));
    ioge_fetch_model fetch_u (.clk_sys(clk_sys), .instr_ready(instr_ready),
        .instr_valid(instr_valid), .instr_word(instr_word));

    // ****************************************
    // compare and report
    // ****************************************
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // write one file register while idle; instructions must wait
    task automatic preload(input logic [IOGE_AW-1:0] a, input logic [IOGE_DW-1:0] d);
        @(negedge clk_sys);
        preload_en   = 1'b1;
        preload_addr = a;
        preload_data = d;
        ram_m[a]     = d;
        #1;
        chk_val(16'(instr_ready), 16'h0000);
        @(negedge clk_sys);
        preload_en = 1'b0;
    endtask

    // ****************************************
    // run one instruction against the model
    // ****************************************
    task automatic exec(input logic [IOGE_IW-1:0] w);
        logic [5:0]         op;
        logic [IOGE_DW-1:0] r;
        bit                 is_f;
        bit                 ok;
        int                 cyc;
        int                 nops;
        int                 got;
        int                 seen;
        op   = w[OPC_HI:OPC_LO];
        is_f = (op == OPC_INC_REG) || (op == OPC_INC_SKIP) || (op == OPC_OR_REG);
        r    = (op == OPC_OR_LIT) ? (acc_m | w[7:0]) :
               (op == OPC_OR_REG) ? (acc_m | ram_m[w[6:0]]) : ram_m[w[6:0]] + DATA_ONE;
        cyc  = is_f ? 2 : 1;
        nops = 0;
        pc_m = pc_m + PC_STEP;
        if (w[OPC_HI:BRC_LO] == OPC_BRANCH)
        begin
            pc_m = {program_page_latch[PAGE_HI:PAGE_LO], w[BRC_LO-1:0]};
            cyc  = 2;
            nops = 1;
        end
        else if (is_f || op == OPC_OR_LIT)
        begin
            if (is_f && w[DEST_BIT])
                ram_m[w[6:0]] = r;
            else
                acc_m = r;
            if (op != OPC_INC_SKIP)
                z_m = (r == DATA_ZERO);
            else if (r == DATA_ZERO)
            begin
                cyc  = 3;
                nops = 1;
                pc_m = pc_m + PC_STEP;
            end
        end
        fetch_u.send(w, ok);
        got  = 0;
        seen = 0;
        do
        begin
            @(negedge clk_sys);
            got++;
            if (no_operation_r === 1'b1)
                seen++;
        end while (instr_done_r !== 1'b1 && got < 8);
        if (!ok || instr_done_r !== 1'b1)
        begin
            mismatches++;
            report_and_stop();
        end
        chk_val(16'(got), 16'(cyc));
        chk_val(16'(seen), 16'(nops));
        chk_val(16'(accum_r), 16'(acc_m));
        chk_val(16'(zero_flag_r), 16'(z_m));
        chk_val(16'(pc_r), 16'(pc_m));
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic scn_reset();
        chk_val(16'(accum_r), 16'h0000);
        chk_val(16'(pc_r), 16'h0000);
        chk_val(16'({zero_flag_r, instr_done_r, no_operation_r}), 16'h0000);
    endtask

    // zero from an or, then or with a register to both places
    task automatic scn_or();
        exec({OPC_OR_LIT, 8'h00});
        exec({OPC_OR_LIT, 8'ha5});
        preload(7'h03, 8'h5a);
        exec({OPC_OR_REG, 1'b1, 7'h03});
        exec({OPC_OR_REG, 1'b0, 7'h03});
    endtask

    // wrap from all ones into the file register, then increments to the accumulator
    task automatic scn_increment_register();
        preload(7'h7f, 8'hff);
        exec({OPC_INC_REG, 1'b1, 7'h7f});
        exec({OPC_INC_REG, 1'b0, 7'h7f});
        exec({OPC_INC_REG, 1'b0, 7'h03});
    endtask

    // skip only on a zero result, flag left alone
    task automatic scn_skip();
        preload(7'h10, 8'hfe);
        exec({OPC_INC_SKIP, 1'b1, 7'h10});
        exec({OPC_OR_LIT, 8'h01});
        exec({OPC_INC_SKIP, 1'b0, 7'h10});
        exec({OPC_INC_SKIP, 1'b1, 7'h10});
    endtask

    // branch targets at both ends, pages 3, 0 and 1; an undecoded word steps on
    task automatic scn_branch();
        program_page_latch = 8'h18;
        exec({OPC_BRANCH, 11'h7ff});
        program_page_latch = 8'he7;
        exec({OPC_BRANCH, 11'h000});
        program_page_latch = 8'h08;
        exec({OPC_BRANCH, 11'h2a5});
        exec(14'h0000);
    endtask

    // reset in mid-run, then the core resumes from the reset state
    task automatic scn_rerun();
        exec({OPC_OR_LIT, 8'h81});
        @(negedge clk_sys);
        rst = 1'b1;
        @(negedge clk_sys);
        scn_reset();
        rst   = 1'b0;
        acc_m = ACC_RST;
        z_m   = 1'b0;
        pc_m  = PC_RST;
        exec({OPC_OR_LIT, 8'h3c});
    endtask

    // clock at 40 MHz
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // main sequence
    initial
    begin
        rst = 1'b1;
        program_page_latch = 8'h00;
        preload_en = 1'b0;
        preload_addr = 7'h00;
        preload_data = 8'h00;
        acc_m = ACC_RST;
        z_m = 1'b0;
        pc_m = PC_RST;
        mismatches = 0;
        num_checks = 0;
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        scn_reset();
        scn_or();
        scn_increment_register();
        scn_skip();
        scn_branch();
        scn_rerun();
        report_and_stop();
    end
endmodule
